// ==== verif/spi_host_model.sv ====
// Host serial master model driving the link pins of the front end
`timescale 1ns/100ps
module spi_host_model (
  input wire logic clk,
  input wire logic [3:0] io_wire,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] drv,
  output logic [3:0] drv_oe
);
  logic mode;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv = 4'hF;
    drv_oe = 4'h0;
    mode = 1'b0;
  end
  // Pin changes land just after a system clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic hold_low();
    cs_n = 1'b0;
  endtask
  // Clock rests at the mode level across both select edges
  task automatic open_frame(input logic m);
    mode = m;
    sclk = m;
    cs_n = 1'b1;
    tick(4);
    cs_n = 1'b0;
    tick(4);
  endtask
  task automatic close_frame();
    if (mode == 1'b0) sclk = 1'b0;
    drv_oe = 4'h0;
    tick(4);
    cs_n = 1'b1;
    tick(5);
  endtask
  // High bits first, w lanes per clock, set up while the clock is low
  task automatic send(input logic [31:0] v, input int n, input int w);
    for (int i = n - w; i >= 0; i -= w) begin
      sclk = 1'b0;
      drv_oe = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
      drv = 4'(v >> i);
      tick(5);
      sclk = 1'b1;
      tick(3);
    end
  endtask
  // Long low phase gives the synced output time to settle before capture
  task automatic recv(output logic [31:0] v, input int n, input int w);
    v = 32'h0;
    drv_oe = 4'h0;
    for (int i = 0; i < n; i += w) begin
      sclk = 1'b0;
      tick(5);
      sclk = 1'b1;
      v = (v << w) | ((w == 1) ? 32'(io_wire[1]) : 32'(io_wire & ((4'h1 << w) - 4'h1)));
      tick(3);
    end
  endtask
  task automatic pause(input logic p);
    drv[3] = 1'b0;
    drv_oe[3] = p;
  endtask
endmodule

// ==== verif/spi_nand_serial_front_end_tb.sv ====
// Self-checking bench for the serial NAND front end
`timescale 1ns/100ps
module spi_nand_serial_front_end_tb;
  logic clk = 1'b0;
  logic srst, quad_enable_bit, array_busy, arr_wr_en;
  logic [11:0] arr_col;
  logic [7:0] arr_wdata;
  logic sclk, cs_n, array_start, load_overrun, start_seen, oe_seen;
  logic [3:0] io_out, io_oe, drv, drv_oe, io_wire;
  logic [3:0] float_v = 4'h0;
  logic [7:0] arr_rdata;
  spi_front_pkg::array_cmd_t array_cmd, cmd_seen;
  int bad_count = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  // Released lanes 0 and 1 toggle so a stale level is never read back; 2 and 3 have pull-ups
  always @(posedge clk) float_v <= ~io_wire;
  assign io_wire = (io_oe & io_out) | (~io_oe & drv_oe & drv) | (~io_oe & ~drv_oe & {2'b11, float_v[1:0]});
  always @(posedge clk) begin
    if (array_start === 1'b1) begin
      start_seen <= 1'b1;
      cmd_seen <= array_cmd;
    end
    if (io_oe !== 4'h0) oe_seen <= 1'b1;
  end
  spi_host_model u_host (.clk(clk), .io_wire(io_wire), .sclk(sclk), .cs_n(cs_n), .drv(drv), .drv_oe(drv_oe));
  spi_nand_serial_front_end u_dut (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .io_in(io_wire),
    .io_out(io_out), .io_oe(io_oe), .quad_enable_bit(quad_enable_bit), .array_busy(array_busy),
    .arr_wr_en(arr_wr_en), .arr_col(arr_col), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata),
    .array_start(array_start), .array_cmd(array_cmd), .load_overrun(load_overrun));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic buf_chk(input logic [11:0] col, input logic [7:0] exp);
    arr_col = col;
    u_host.tick(3);
    chk("arr_rdata", 32'(exp), 32'(arr_rdata));
  endtask
  task automatic do_exec(input logic m, input logic [7:0] opc, input logic [15:0] row, input int n,
    input logic want, input logic [1:0] op);
    start_seen = 1'b0;
    u_host.open_frame(m);
    u_host.send(32'(opc), 8, 1);
    u_host.send(32'({8'h00, row}) >> (24 - n), n, 1);
    u_host.close_frame();
    u_host.tick(3);
    chk("array_start", 32'(want), 32'(start_seen));
    if (want) chk("array_cmd", 32'({op, row[15:6], row[5:0]}), 32'(cmd_seen));
    $display("exec %h test done", opc);
  endtask
  task automatic do_load(input logic [7:0] opc, input int w, input logic [11:0] col, input logic [15:0] dat,
    input int extra);
    u_host.open_frame(1'b0);
    u_host.send(32'(opc), 8, 1);
    u_host.send(32'({4'h0, col}), 16, 1);
    u_host.send(32'(dat), 16, w);
    repeat (extra) u_host.send(32'h0000_00A5, 8, w);
    u_host.close_frame();
    u_host.tick(4);
    $display("load %h test done", opc);
  endtask
  // Read split after the first byte so a pause can sit inside the data phase
  task automatic do_read(input logic m, input logic [7:0] opc, input int w, input int n, input logic [11:0] col,
    input logic [31:0] exp, input logic pz, input logic want);
    logic [31:0] g1, g2;
    int aw;
    // Dual I/O takes address and dummy on two lanes; the rest use one
    aw = (opc == 8'hBB) ? 2 : 1;
    oe_seen = 1'b0;
    u_host.open_frame(m);
    u_host.send(32'(opc), 8, 1);
    u_host.send(32'({4'h0, col}), 16, aw);
    u_host.send(32'h0, 8, aw);
    u_host.recv(g1, 8, w);
    if (pz) begin
      u_host.pause(1'b1);
      u_host.tick(8);
      chk("io_oe paused", 32'h0, 32'(io_oe));
      u_host.pause(1'b0);
      u_host.tick(4);
    end
    u_host.recv(g2, n - 8, w);
    u_host.close_frame();
    if (want) chk("read data", exp, (g1 << (n - 8)) | g2);
    else chk("io_oe refused", 32'h0, 32'(oe_seen));
    chk("io_oe deselected", 32'h0, 32'(io_oe));
    $display("read %h test done", opc);
  endtask
  task automatic do_unarmed();
    start_seen = 1'b0;
    u_host.send(32'h1300_ABCD, 32, 1);
    u_host.close_frame();
    u_host.tick(3);
    chk("array_start unarmed", 32'h0, 32'(start_seen));
    $display("unarmed test done");
  endtask
  task automatic do_arr_write(input logic [11:0] col, input logic [7:0] dat);
    arr_col = col;
    arr_wdata = dat;
    arr_wr_en = 1'b1;
    u_host.tick(1);
    arr_wr_en = 1'b0;
    buf_chk(col, dat);
    $display("array write test done");
  endtask
  // Drain stalled so the sixteen-word buffer must refuse
  task automatic do_overrun();
    array_busy = 1'b1;
    do_load(8'h02, 1, 12'h100, 16'h1111, 18);
    chk("load_overrun", 32'h1, 32'(load_overrun));
    array_busy = 1'b0;
    $display("overrun test done");
  endtask
  initial begin
    srst = 1'b1;
    quad_enable_bit = 1'b0;
    array_busy = 1'b0;
    arr_wr_en = 1'b0;
    arr_col = 12'h000;
    arr_wdata = 8'h00;
    #1;
    u_host.hold_low();
    repeat (8) @(posedge clk);
    #1;
    srst = 1'b0;
    do_unarmed();
    do_exec(1'b0, 8'h13, 16'hABCD, 24, 1'b1, 2'h1);
    do_exec(1'b1, 8'h10, 16'h0040, 24, 1'b1, 2'h2);
    do_exec(1'b0, 8'hD8, 16'hFFFF, 24, 1'b1, 2'h3);
    do_exec(1'b0, 8'h13, 16'h1234, 16, 1'b0, 2'h1);
    do_load(8'h02, 1, 12'h010, 16'h5AC3, 0);
    buf_chk(12'h010, 8'h5A);
    buf_chk(12'h011, 8'hC3);
    quad_enable_bit = 1'b1;
    do_load(8'h32, 4, 12'h020, 16'h9E71, 0);
    buf_chk(12'h020, 8'h9E);
    buf_chk(12'h021, 8'h71);
    do_arr_write(12'h030, 8'h66);
    buf_chk(12'h840, 8'hFF);
    do_read(1'b1, 8'h03, 1, 16, 12'h010, 32'h5AC3, 1'b1, 1'b1);
    do_read(1'b0, 8'h3B, 2, 16, 12'h010, 32'h5AC3, 1'b0, 1'b1);
    do_read(1'b0, 8'h6B, 4, 16, 12'h020, 32'h9E71, 1'b0, 1'b1);
    do_read(1'b0, 8'hBB, 2, 16, 12'h020, 32'h9E71, 1'b1, 1'b1);
    do_read(1'b1, 8'h03, 1, 16, 12'h840, 32'hFFFF, 1'b0, 1'b1);
    quad_enable_bit = 1'b0;
    do_read(1'b0, 8'h6B, 4, 16, 12'h020, 32'h0, 1'b0, 1'b0);
    do_overrun();
    print_verdict();
  end
  initial begin
    // Nearly four times the expected length of the whole run
    #200000;
    bad_count++;
    print_verdict();
  end
endmodule

// ==== verilog/load_fifo.sv ====
// Parameterised FIFO between the serial loader and the page buffer
`timescale 1ns/100ps
module load_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = wr_ptr == rd_ptr;
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (AW+1)'(push);
      rd_ptr <= rd_ptr + (AW+1)'(pop);
    end
  end
endmodule

// ==== verilog/spi_front_pkg.sv ====
// Types shared by the serial NAND front end
`include "spi_front_regs.svh"
package spi_front_pkg;
  typedef enum logic [7:0] {
    PH_IDLE = 8'h01,
    PH_OPC = 8'h02,
    PH_ADDR = 8'h04,
    PH_DUMMY = 8'h08,
    PH_DIN = 8'h10,
    PH_DOUT = 8'h20,
    PH_EXEC = 8'h40,
    PH_IGNORE = 8'h80
  } phase_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_PAGE_READ = 2'h1,
    OP_PROGRAM = 2'h2,
    OP_ERASE = 2'h3
  } array_op_t;

  typedef struct packed {
    logic [`COL_W-1:0] col;
    logic [7:0] data;
  } load_word_t;

  typedef struct packed {
    array_op_t op;
    logic [`BLOCK_W-1:0] block;
    logic [`PAGE_W-1:0] page;
  } array_cmd_t;

  typedef struct packed {
    logic valid;
    logic quad;
    logic exec;
    logic dir_in;
    array_op_t op;
    logic [2:0] addr_w;
    logic [4:0] addr_clks;
    logic [4:0] dummy_clks;
    logic [2:0] data_w;
  } cmd_info_t;
endpackage

// ==== verilog/spi_front_regs.svh ====
// Constants of the serial NAND front end
// Function
// - Works with host clock mode 0 or mode 3 without any setting.
// - Instruction, address and write data are sampled on rising clock edges.
// - Output lanes change after falling clock edges; host captures on rising.
// - Select high: device ignores bus and tri-states all lanes.
// - Started array operations finish even after select is released.
// - After power-up no instruction is taken before select goes high then low.
// - Dual commands turn lanes 0 and 1 into two-bit-per-clock lanes.
// - Quad commands add lanes 2 and 3 for four bits per clock.
// - Four-lane commands are refused unless quad enable bit is set.
// - Opcode always comes from lane 0 only.
// - Column address is 12 bits; offsets from 2112 are out of bounds.
// - Row bits 5..0 select page, bits 15..6 select block.
// - Array is 1024 blocks of 64 pages of 2K plus 64 bytes.
// - A page-sized buffer sits between array and serial interface.
// - Pause low in single or dual mode tri-states output and ignores inputs.
// - Dual output: lane 0 carries even bits, lane 1 odd, high pair first.
`ifndef SPI_FRONT_REGS_SVH
`define SPI_FRONT_REGS_SVH
`define COL_W 12
`define COL_LIMIT 12'h840
`define PAGE_BYTES 2112
`define PAGE_W 6
`define BLOCK_W 10
`define ROW_PAGE_LSB 0
`define ROW_BLOCK_LSB 6
`define ROW_W 16
`define LOAD_FIFO_DEPTH 16
`define FILL_BYTE 8'hFF
`define LANE_X1 3'h1
`define LANE_X2 3'h2
`define LANE_X4 3'h4
`define ADDR_CLKS_COL_X1 5'h10
`define ADDR_CLKS_COL_X2 5'h08
`define ADDR_CLKS_ROW 5'h18
`define DUMMY_CLKS_X1 5'h08
`define DUMMY_CLKS_X2 5'h04
`define OPC_CLKS 5'h08
`define OPC_LOAD_X1 8'h02
`define OPC_LOAD_X4 8'h32
`define OPC_READ_X1 8'h03
`define OPC_READ_X2 8'h3B
`define OPC_READ_X4 8'h6B
`define OPC_READ_DIO 8'hBB
`define OPC_PAGE_READ 8'h13
`define OPC_PROG_EXEC 8'h10
`define OPC_ERASE 8'hD8
`define SYNC_RST 6'h00
`endif

// ==== verilog/spi_nand_serial_front_end.sv ====
// Serial front end: pin sampling, command framing, lane steering and page buffer
`timescale 1ns/100ps
`include "spi_front_regs.svh"
module spi_nand_serial_front_end #(
  parameter int FIFO_DEPTH = `LOAD_FIFO_DEPTH,
  parameter int BUF_BYTES = `PAGE_BYTES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic quad_enable_bit,
  input wire logic array_busy,
  input wire logic arr_wr_en,
  input wire logic [`COL_W-1:0] arr_col,
  input wire logic [7:0] arr_wdata,
  output logic [7:0] arr_rdata,
  output logic array_start,
  output spi_front_pkg::array_cmd_t array_cmd,
  output logic load_overrun
);
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic sclk_d;
  logic [7:0] page_buf [BUF_BYTES];
  spi_front_pkg::phase_t phase;
  spi_front_pkg::cmd_info_t info;
  logic [4:0] cnt;
  logic [3:0] ocnt;
  logic [23:0] sr;
  logic [7:0] obyte;
  logic [2:0] lane_w;
  logic [`COL_W-1:0] col;
  logic [`ROW_W-1:0] row;
  logic armed;
  logic quad_cmd;
  logic drive_on;

  // Pins come from the host's domain: two flops before any use
  wire [5:0] raw_pins = {io_in, cs_n, sclk};
  wire [5:0] sync_rst = `SYNC_RST; // Select resets low so a select already low at release never arms
  for (genvar i = 0; i < 6; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (srst) begin
        sync1[i] <= sync_rst[i];
        sync2[i] <= sync_rst[i];
      end else begin
        sync1[i] <= raw_pins[i];
        sync2[i] <= sync1[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sync2[0];
    end
  end

  function automatic spi_front_pkg::cmd_info_t decode_cmd(input logic [7:0] opc);
    spi_front_pkg::cmd_info_t c;
    c = '0;
    c.valid = 1'b1;
    c.addr_w = `LANE_X1;
    c.addr_clks = `ADDR_CLKS_COL_X1;
    c.data_w = `LANE_X1;
    unique case (opc)
      `OPC_LOAD_X1: c.dir_in = 1'b1;
      `OPC_LOAD_X4: begin
        c.dir_in = 1'b1;
        c.quad = 1'b1;
        c.data_w = `LANE_X4;
      end
      `OPC_READ_X1: c.dummy_clks = `DUMMY_CLKS_X1;
      `OPC_READ_X2: begin
        c.dummy_clks = `DUMMY_CLKS_X1;
        c.data_w = `LANE_X2;
      end
      `OPC_READ_X4: begin
        c.dummy_clks = `DUMMY_CLKS_X1;
        c.data_w = `LANE_X4;
        c.quad = 1'b1;
      end
      `OPC_READ_DIO: begin
        c.addr_w = `LANE_X2;
        c.addr_clks = `ADDR_CLKS_COL_X2;
        c.dummy_clks = `DUMMY_CLKS_X2;
        c.data_w = `LANE_X2;
      end
      `OPC_PAGE_READ, `OPC_PROG_EXEC, `OPC_ERASE: begin
        c.exec = 1'b1;
        c.addr_clks = `ADDR_CLKS_ROW;
        c.op = (opc == `OPC_PAGE_READ) ? spi_front_pkg::OP_PAGE_READ :
               (opc == `OPC_PROG_EXEC) ? spi_front_pkg::OP_PROGRAM : spi_front_pkg::OP_ERASE;
      end
      default: c.valid = 1'b0;
    endcase
    return c;
  endfunction

  // Shared by address and data phases; high bits arrive first
  function automatic logic [23:0] shift_in(input logic [23:0] s, input logic [3:0] l, input logic [2:0] w);
    return (w == `LANE_X4) ? {s[19:0], l} :
           (w == `LANE_X2) ? {s[21:0], l[1:0]} : {s[22:0], l[0]};
  endfunction

  // Edge detection works for either idle level, so mode 0 and mode 3 need no setting
  wire cs_hi = sync2[1];
  wire [3:0] lanes = sync2[5:2];
  wire hold_active = !cs_hi && !quad_cmd && !lanes[3];
  wire rise_ok = sync2[0] && !sclk_d && !cs_hi && !hold_active;
  wire fall_ok = !sync2[0] && sclk_d && !cs_hi && !hold_active;
  wire [23:0] next_sr = shift_in(sr, lanes, lane_w);
  wire [7:0] opcode_in = {sr[6:0], lanes[0]};
  wire spi_front_pkg::cmd_info_t opc_info = decode_cmd(opcode_in);
  wire opc_done = phase == spi_front_pkg::PH_OPC && rise_ok && cnt == `OPC_CLKS - 5'h01;
  wire quad_refused = opc_info.quad && !quad_enable_bit;
  wire [3:0] byte_clks = (lane_w == `LANE_X4) ? 4'h2 : (lane_w == `LANE_X2) ? 4'h4 : 4'h8;
  wire byte_last = ocnt == byte_clks - 4'h1;
  wire col_ok = col < `COL_LIMIT;
  wire [7:0] rd_byte = col_ok ? page_buf[col] : `FILL_BYTE;
  wire [7:0] out_src = (ocnt == 4'h0) ? rd_byte : obyte;
  wire [7:0] out_next = (lane_w == `LANE_X4) ? {out_src[3:0], 4'h0} :
                        (lane_w == `LANE_X2) ? {out_src[5:0], 2'h0} : {out_src[6:0], 1'b0};
  wire [3:0] out_bits = (lane_w == `LANE_X4) ? out_src[7:4] :
                        (lane_w == `LANE_X2) ? {2'h0, out_src[7:6]} : {2'h0, out_src[7], 1'b0};
  wire [3:0] oe_mask = (lane_w == `LANE_X4) ? 4'hF : (lane_w == `LANE_X2) ? 4'h3 : 4'h2;
  wire byte_in_done = phase == spi_front_pkg::PH_DIN && rise_ok && byte_last;

  spi_front_pkg::load_word_t push_word;
  spi_front_pkg::load_word_t pop_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  assign push_word = '{col: col, data: next_sr[7:0]};
  // Buffer belongs to the array side while it is busy, so loads queue up
  wire drain = fifo_out_valid && !array_busy && !arr_wr_en;

  load_fifo #(
    .WIDTH($bits(spi_front_pkg::load_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_load_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(byte_in_done),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(fifo_out_valid),
    .out_ready(drain),
    .out_data(pop_word)
  );

  // Page buffer: serial loads and array transfers share it
  always_ff @(posedge clk) begin
    if (arr_wr_en && arr_col < `COL_LIMIT) begin
      page_buf[arr_col] <= arr_wdata;
    end else if (drain && pop_word.col < `COL_LIMIT) begin
      page_buf[pop_word.col] <= pop_word.data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      arr_rdata <= 8'h00;
    end else begin
      arr_rdata <= (arr_col < `COL_LIMIT) ? page_buf[arr_col] : `FILL_BYTE;
    end
  end

  // Command framing
  always_ff @(posedge clk) begin
    if (srst) begin
      phase <= spi_front_pkg::PH_IDLE;
      info <= '0;
      cnt <= 5'h00;
      ocnt <= 4'h0;
      sr <= 24'h000000;
      lane_w <= `LANE_X1;
      col <= '0;
      row <= '0;
      armed <= 1'b0;
      quad_cmd <= 1'b0;
      load_overrun <= 1'b0;
    end else if (cs_hi) begin
      phase <= spi_front_pkg::PH_IDLE;
      armed <= 1'b1;
      quad_cmd <= 1'b0;
      lane_w <= `LANE_X1;
      cnt <= 5'h00;
    end else begin
      unique case (phase)
        spi_front_pkg::PH_IDLE: begin
          load_overrun <= 1'b0;
          phase <= armed ? spi_front_pkg::PH_OPC : spi_front_pkg::PH_IGNORE;
        end
        spi_front_pkg::PH_OPC: if (rise_ok) begin
          sr <= next_sr;
          cnt <= cnt + 5'h01;
          if (opc_done) begin
            info <= opc_info;
            cnt <= 5'h00;
            lane_w <= opc_info.addr_w;
            quad_cmd <= opc_info.quad;
            phase <= (!opc_info.valid || quad_refused) ? spi_front_pkg::PH_IGNORE : spi_front_pkg::PH_ADDR;
          end
        end
        spi_front_pkg::PH_ADDR: if (rise_ok) begin
          sr <= next_sr;
          cnt <= cnt + 5'h01;
          if (cnt == info.addr_clks - 5'h01) begin
            cnt <= 5'h00;
            ocnt <= 4'h0;
            row <= next_sr[`ROW_W-1:0];
            col <= next_sr[`COL_W-1:0];
            lane_w <= info.data_w;
            phase <= info.exec ? spi_front_pkg::PH_EXEC :
                     (info.dummy_clks != 5'h00) ? spi_front_pkg::PH_DUMMY :
                     info.dir_in ? spi_front_pkg::PH_DIN : spi_front_pkg::PH_DOUT;
          end
        end
        spi_front_pkg::PH_DUMMY: if (rise_ok) begin
          cnt <= cnt + 5'h01;
          if (cnt == info.dummy_clks - 5'h01) begin
            phase <= spi_front_pkg::PH_DOUT;
          end
        end
        spi_front_pkg::PH_DIN: if (rise_ok) begin
          sr <= next_sr;
          ocnt <= byte_last ? 4'h0 : ocnt + 4'h1;
          if (byte_last) begin
            col <= col + `COL_W'(1);
            if (!fifo_in_ready) begin
              load_overrun <= 1'b1;
              phase <= spi_front_pkg::PH_IGNORE;
            end
          end
        end
        spi_front_pkg::PH_DOUT: if (fall_ok) begin
          ocnt <= byte_last ? 4'h0 : ocnt + 4'h1;
          if (ocnt == 4'h0) begin
            col <= col + `COL_W'(1);
          end
        end
        spi_front_pkg::PH_EXEC, spi_front_pkg::PH_IGNORE: ;
      endcase
    end
  end

  // Output lanes move only on falling edges and float whenever not driving
  always_ff @(posedge clk) begin
    if (srst) begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
      obyte <= 8'h00;
      drive_on <= 1'b0;
    end else begin
      if (phase == spi_front_pkg::PH_DOUT && fall_ok) begin
        io_out <= out_bits;
        obyte <= out_next;
        drive_on <= 1'b1;
      end else if (phase != spi_front_pkg::PH_DOUT) begin
        drive_on <= 1'b0;
      end
      io_oe <= (cs_hi || hold_active || !drive_on || phase != spi_front_pkg::PH_DOUT) ? 4'h0 : oe_mask;
    end
  end

  // Array commands fire only once framing ended cleanly; the array runs on regardless of select
  always_ff @(posedge clk) begin
    if (srst) begin
      array_start <= 1'b0;
      array_cmd <= '0;
    end else begin
      array_start <= cs_hi && phase == spi_front_pkg::PH_EXEC;
      if (cs_hi && phase == spi_front_pkg::PH_EXEC) begin
        array_cmd <= '{op: info.op, block: row[`ROW_BLOCK_LSB +: `BLOCK_W], page: row[`ROW_PAGE_LSB +: `PAGE_W]};
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_dout_fetch;
    phase == spi_front_pkg::PH_DOUT && fall_ok && ocnt == 4'h0;
  endsequence

  sequence s_exec_end;
    phase == spi_front_pkg::PH_EXEC && cs_hi;
  endsequence

  property p_deselect_hiz;
    cs_hi |=> io_oe == 4'h0;
  endproperty
  a_deselect_hiz: assert property (p_deselect_hiz) else $error("lanes driven while deselected");

  property p_power_up_gate;
    !armed |=> phase != spi_front_pkg::PH_OPC;
  endproperty
  a_power_up_gate: assert property (p_power_up_gate) else $error("opcode taken before first select");

  property p_quad_gate;
    opc_done && quad_refused |=> phase == spi_front_pkg::PH_IGNORE;
  endproperty
  a_quad_gate: assert property (p_quad_gate) else $error("quad command taken without quad enable");

  property p_opcode_lane0;
    opc_done && opc_info.valid && !quad_refused |=> info == decode_cmd({$past(sr[6:0]), $past(lanes[0])});
  endproperty
  a_opcode_lane0: assert property (p_opcode_lane0) else $error("opcode not from lane 0");

  property p_row_decode;
    array_start |-> array_cmd.page == row[5:0] && array_cmd.block == row[15:6];
  endproperty
  a_row_decode: assert property (p_row_decode) else $error("row address split wrong");

  property p_exec_on_deselect;
    array_start |-> $past(phase) == spi_front_pkg::PH_EXEC && $past(cs_hi);
  endproperty
  a_exec_on_deselect: assert property (p_exec_on_deselect) else $error("array start without full command");

  property p_exec_fires;
    s_exec_end |=> array_start ##1 !array_start;
  endproperty
  a_exec_fires: assert property (p_exec_fires) else $error("array start not a single pulse");

  property p_hold_tristate;
    hold_active |=> io_oe == 4'h0;
  endproperty
  a_hold_tristate: assert property (p_hold_tristate) else $error("lanes driven while paused");

  property p_out_after_fall;
    $changed(io_out) |-> $past(fall_ok);
  endproperty
  a_out_after_fall: assert property (p_out_after_fall) else $error("output changed without falling edge");

  property p_sample_on_rise;
    $changed(sr) |-> $past(rise_ok);
  endproperty
  a_sample_on_rise: assert property (p_sample_on_rise) else $error("input sampled off rising edge");

  property p_oob_read;
    s_dout_fetch ##0 (!col_ok && lane_w == `LANE_X1) |=> io_out[1];
  endproperty
  a_oob_read: assert property (p_oob_read) else $error("out of bounds read not filled");

  property p_dual_lanes;
    io_oe == 4'h3 |-> lane_w == `LANE_X2 && !$past(cs_hi);
  endproperty
  a_dual_lanes: assert property (p_dual_lanes) else $error("two lanes driven outside dual mode");
endmodule
